// ### hdl/spcr_map.svh
// Purpose: Offsets, bit positions and reset values of the serial port configuration registers
// Assumes: 12-bit register addresses, 8-bit register data
// Notes on behaviour
// - Bit 7 of register 0x000 selects SPI data mode; ignored in I2C mode.
// - Bit 7 low: bidirectional pin reads and writes; serial output pin stays undriven.
// - Bit 6 low: MSB first, address decrements in multibyte transfers.
// - Bit 6 high: LSB first, address increments in multibyte transfers.
// - Bit-order setting applies only to SPI, ignored in I2C mode.
// - Writing bit 5 high restores register defaults, then bit clears itself.
// - Readback select low: buffered registers read back their active values.
// - Readback select high: buffered registers read back pending buffer values.
`ifndef SPCR_MAP_SVH
`define SPCR_MAP_SVH
`define SPCR_ADDR_CONFIG 12'h000
`define SPCR_ADDR_RB_SEL 12'h004
`define SPCR_BIT_UNIDIR 7
`define SPCR_BIT_LSB_FIRST 6
`define SPCR_BIT_SOFT_RST 5
`define SPCR_BIT_RB_BUFFER 0
`define SPCR_BIT_RESERVED 4
`define SPCR_BIT_MIR_RESERVED 3
`define SPCR_BIT_MIR_SOFT_RST 2
`define SPCR_BIT_MIR_LSB_FIRST 1
`define SPCR_BIT_MIR_UNIDIR 0
`define SPCR_RST_UNIDIR 1'h0
`define SPCR_RST_LSB_FIRST 1'h0
`define SPCR_RST_RB_BUFFER 1'h0
`define SPCR_RST_SOFT_RST 1'h0
`define SPCR_RST_RVALID 1'h0
`define SPCR_ZERO_BYTE 8'h00
`endif

// ### hdl/spcr_pkg.sv
// Purpose: Types of the serial port configuration register block
// Assumes: Constants live in spcr_map.svh
// Notes: State of the block is one packed struct
package spcr_pkg;
	typedef logic [11:0] spcr_addr_type;
	typedef logic [7:0] spcr_byte_type;
	typedef struct packed {
		logic unidir;
		logic lsb_first;
		logic rb_buffer;
		logic soft_rst;
		logic rvalid;
		spcr_byte_type rdata;
	} spcr_state_type;
endpackage

// ### hdl/spcr_regs.sv
// Purpose: Serial port configuration and readback-source registers behind the register-access layer
// Assumes: Access layer runs on this clock; one access per cycle, read data one cycle later
// Notes: Other register banks sit outside; their readback goes through the mux here
`timescale 1ns/1ps
`include "spcr_map.svh"
`default_nettype none
module spcr_regs
	import spcr_pkg::*;
(
	input wire logic clock,
	input wire logic arst_n,
	input wire logic i2c_mode,
	input wire logic wr_en,
	input wire logic rd_en,
	input wire spcr_addr_type addr,
	input wire spcr_byte_type wdata,
	input wire logic read_phase,
	input wire logic ext_buffered,
	input wire spcr_byte_type ext_active_data,
	input wire spcr_byte_type ext_buffer_data,
	output spcr_byte_type rdata,
	output logic rvalid,
	output logic unidir_mode_select,
	output logic lsb_first,
	output logic addr_increment,
	output logic soft_reset,
	output logic sdio_read_oe,
	output logic serial_out_pin_oe
);
	spcr_state_type st_q;
	spcr_state_type st_d;

	function automatic logic hit(input spcr_addr_type a, input spcr_addr_type off);
		hit = (a == off);
	endfunction

	function automatic spcr_byte_type mirror(input logic [3:0] hi);
		mirror = {hi, hi[0], hi[1], hi[2], hi[3]};
	endfunction

	always_comb begin
		st_d = st_q;
		st_d.soft_rst = 1'h0;
		st_d.rvalid = rd_en;
		if (rd_en) begin
			if (hit(addr, `SPCR_ADDR_CONFIG)) begin
				// Soft reset bit reads high only in its one active cycle
				st_d.rdata = mirror({st_q.unidir, st_q.lsb_first, st_q.soft_rst, 1'h0});
			end else if (hit(addr, `SPCR_ADDR_RB_SEL)) begin
				st_d.rdata = `SPCR_ZERO_BYTE;
				st_d.rdata[`SPCR_BIT_RB_BUFFER] = st_q.rb_buffer;
			end else if (ext_buffered && st_q.rb_buffer) begin
				st_d.rdata = ext_buffer_data;
			end else if (ext_buffered) begin
				st_d.rdata = ext_active_data;
			end else begin
				st_d.rdata = ext_active_data;
			end
		end
		if (wr_en && hit(addr, `SPCR_ADDR_CONFIG)) begin
			// Only the upper nibble is decoded; the mirror nibble is the host's duty
			st_d.unidir = wdata[`SPCR_BIT_UNIDIR];
			st_d.lsb_first = wdata[`SPCR_BIT_LSB_FIRST];
		end
		if (wr_en && hit(addr, `SPCR_ADDR_RB_SEL)) begin
			st_d.rb_buffer = wdata[`SPCR_BIT_RB_BUFFER];
		end
		if (st_q.soft_rst) begin
			// Defaults win over any write landing in the reset cycle
			st_d.unidir = `SPCR_RST_UNIDIR;
			st_d.lsb_first = `SPCR_RST_LSB_FIRST;
			st_d.rb_buffer = `SPCR_RST_RB_BUFFER;
		end
		if (wr_en && hit(addr, `SPCR_ADDR_CONFIG) && wdata[`SPCR_BIT_SOFT_RST]) begin
			st_d.soft_rst = 1'h1;
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			st_q.unidir <= `SPCR_RST_UNIDIR;
			st_q.lsb_first <= `SPCR_RST_LSB_FIRST;
			st_q.rb_buffer <= `SPCR_RST_RB_BUFFER;
			st_q.soft_rst <= `SPCR_RST_SOFT_RST;
			st_q.rvalid <= `SPCR_RST_RVALID;
			st_q.rdata <= `SPCR_ZERO_BYTE;
		end else begin
			st_q <= st_d;
		end
	end

	assign rdata = st_q.rdata;
	assign rvalid = st_q.rvalid;
	assign soft_reset = st_q.soft_rst;
	// I2C has its own framing, so both SPI options are forced inactive there
	assign unidir_mode_select = st_q.unidir && !i2c_mode;
	assign lsb_first = st_q.lsb_first && !i2c_mode;
	assign addr_increment = st_q.lsb_first && !i2c_mode;
	assign sdio_read_oe = read_phase && !unidir_mode_select;
	assign serial_out_pin_oe = read_phase && unidir_mode_select;

	// Decoded accesses, shared by the checks below
	logic cfg_write;
	logic rb_write;
	logic soft_write;
	logic cfg_read;
	logic rb_read;
	logic ext_read;

	assign cfg_write = wr_en && hit(addr, `SPCR_ADDR_CONFIG);
	assign rb_write = wr_en && hit(addr, `SPCR_ADDR_RB_SEL);
	assign soft_write = cfg_write && wdata[`SPCR_BIT_SOFT_RST];
	assign cfg_read = rd_en && hit(addr, `SPCR_ADDR_CONFIG);
	assign rb_read = rd_en && hit(addr, `SPCR_ADDR_RB_SEL);
	assign ext_read = rd_en && !cfg_read && !rb_read;

	// A rewrite of the bit inside the pulse restarts it, since the set wins
	soft_reset_one_a: assert property (@(posedge clock) disable iff (!arst_n)
		(soft_reset && !soft_write)
		|=> !soft_reset)
		else $error("Soft reset longer than one cycle");
	soft_reset_cause_a: assert property (@(posedge clock) disable iff (!arst_n)
		soft_write
		|=> soft_reset)
		else $error("Soft reset write not taken");
	soft_reset_defaults_a: assert property (@(posedge clock) disable iff (!arst_n)
		soft_reset
		|=> (st_q.unidir == `SPCR_RST_UNIDIR && st_q.lsb_first == `SPCR_RST_LSB_FIRST
		&& st_q.rb_buffer == `SPCR_RST_RB_BUFFER))
		else $error("Defaults not restored");

	mode_i2c_gate_a: assert property (@(posedge clock) disable iff (!arst_n)
		i2c_mode
		|-> (!unidir_mode_select && !lsb_first && !addr_increment))
		else $error("SPI options active in I2C mode");
	mode_write_a: assert property (@(posedge clock) disable iff (!arst_n)
		(cfg_write && !wdata[`SPCR_BIT_SOFT_RST] && !soft_reset && !i2c_mode) ##1 !i2c_mode
		|-> unidir_mode_select == $past(wdata[`SPCR_BIT_UNIDIR]))
		else $error("Data mode not applied");
	unidir_write_a: assert property (@(posedge clock) disable iff (!arst_n)
		(cfg_write && !soft_reset)
		|=> st_q.unidir == $past(wdata[`SPCR_BIT_UNIDIR]))
		else $error("Data mode bit not stored");
	order_write_a: assert property (@(posedge clock) disable iff (!arst_n)
		(cfg_write && !soft_reset)
		|=> st_q.lsb_first == $past(wdata[`SPCR_BIT_LSB_FIRST]))
		else $error("Bit order not stored");
	mode_hold_a: assert property (@(posedge clock) disable iff (!arst_n)
		(!cfg_write && !soft_reset)
		|=> ($stable(st_q.unidir) && $stable(st_q.lsb_first)))
		else $error("Mode bits changed without a write");
	order_step_a: assert property (@(posedge clock) disable iff (!arst_n)
		lsb_first == addr_increment)
		else $error("Bit order and address step disagree");
	msb_default_a: assert property (@(posedge clock) disable iff (!arst_n)
		(!i2c_mode && !st_q.lsb_first)
		|-> (!lsb_first && !addr_increment))
		else $error("Bit order not MSB first with decrement");
	lsb_set_a: assert property (@(posedge clock) disable iff (!arst_n)
		(!i2c_mode && st_q.lsb_first)
		|-> (lsb_first && addr_increment))
		else $error("Bit order not LSB first with increment");

	pin_enable_excl_a: assert property (@(posedge clock) disable iff (!arst_n)
		!(sdio_read_oe && serial_out_pin_oe))
		else $error("Both read pins driven");
	bidir_pins_a: assert property (@(posedge clock) disable iff (!arst_n)
		(read_phase && !i2c_mode && !st_q.unidir)
		|-> (sdio_read_oe && !serial_out_pin_oe))
		else $error("Serial out driven in bidirectional mode");
	unidir_pins_a: assert property (@(posedge clock) disable iff (!arst_n)
		(read_phase && !i2c_mode && st_q.unidir)
		|-> (serial_out_pin_oe && !sdio_read_oe))
		else $error("Read data not on serial out in unidirectional mode");
	i2c_pins_a: assert property (@(posedge clock) disable iff (!arst_n)
		(read_phase && i2c_mode)
		|-> (sdio_read_oe && !serial_out_pin_oe))
		else $error("Data mode bit honoured in I2C mode");
	oe_idle_a: assert property (@(posedge clock) disable iff (!arst_n)
		!read_phase
		|-> (!sdio_read_oe && !serial_out_pin_oe))
		else $error("Read pin driven outside read phase");

	rvalid_pulse_a: assert property (@(posedge clock) disable iff (!arst_n)
		rd_en
		|=> rvalid)
		else $error("Read not answered");
	rvalid_idle_a: assert property (@(posedge clock) disable iff (!arst_n)
		!rd_en
		|=> !rvalid)
		else $error("Read valid without a read");
	rdata_hold_a: assert property (@(posedge clock) disable iff (!arst_n)
		!rd_en
		|=> $stable(rdata))
		else $error("Read data changed without a read");
	cfg_read_bits_a: assert property (@(posedge clock) disable iff (!arst_n)
		cfg_read
		|=> (rdata[`SPCR_BIT_UNIDIR] == $past(st_q.unidir) && rdata[`SPCR_BIT_LSB_FIRST] == $past(st_q.lsb_first)
		&& rdata[`SPCR_BIT_SOFT_RST] == $past(st_q.soft_rst) && !rdata[`SPCR_BIT_RESERVED]))
		else $error("Configuration readback wrong");
	cfg_mirror_a: assert property (@(posedge clock) disable iff (!arst_n)
		cfg_read
		|=> (rdata[`SPCR_BIT_MIR_UNIDIR] == rdata[`SPCR_BIT_UNIDIR]
		&& rdata[`SPCR_BIT_MIR_LSB_FIRST] == rdata[`SPCR_BIT_LSB_FIRST]
		&& rdata[`SPCR_BIT_MIR_SOFT_RST] == rdata[`SPCR_BIT_SOFT_RST]
		&& rdata[`SPCR_BIT_MIR_RESERVED] == rdata[`SPCR_BIT_RESERVED]))
		else $error("Configuration readback not mirrored");
	rb_sel_read_a: assert property (@(posedge clock) disable iff (!arst_n)
		rb_read
		|=> rdata[`SPCR_BIT_RB_BUFFER] == $past(st_q.rb_buffer))
		else $error("Readback select not read back");
	rb_sel_write_a: assert property (@(posedge clock) disable iff (!arst_n)
		(rb_write && !soft_reset)
		|=> st_q.rb_buffer == $past(wdata[`SPCR_BIT_RB_BUFFER]))
		else $error("Readback select not stored");
	rb_hold_a: assert property (@(posedge clock) disable iff (!arst_n)
		(!rb_write && !soft_reset)
		|=> $stable(st_q.rb_buffer))
		else $error("Readback select changed without a write");
	rb_buffer_a: assert property (@(posedge clock) disable iff (!arst_n)
		(ext_read && ext_buffered && st_q.rb_buffer)
		|=> rdata == $past(ext_buffer_data))
		else $error("Buffer value not read back");
	rb_active_a: assert property (@(posedge clock) disable iff (!arst_n)
		(ext_read && ext_buffered && !st_q.rb_buffer)
		|=> rdata == $past(ext_active_data))
		else $error("Active value not read back");
	unbuffered_a: assert property (@(posedge clock) disable iff (!arst_n)
		(ext_read && !ext_buffered)
		|=> rdata == $past(ext_active_data))
		else $error("Stored value not read back");
endmodule
`default_nettype wire

// ### sim/spcr_host.sv
// Purpose: Host controller model issuing single-byte register accesses
// Assumes: Strobes change on the falling edge, one access per call
// Notes: Lower nibble of a configuration write is built as the mirror of the upper one
`timescale 1ns/1ps
`default_nettype none
module spcr_host
	import spcr_pkg::*;
(
	input wire logic clock,
	output logic wr_en,
	output logic rd_en,
	output spcr_addr_type addr,
	output spcr_byte_type wdata
);
	initial begin
		{wr_en, rd_en, addr, wdata} = '0;
	end
	task automatic wr(input spcr_addr_type a, input spcr_byte_type d);
		@(negedge clock);
		addr = a;
		wdata = (a == 12'h000) ? {d[7:4], d[4], d[5], d[6], d[7]} : d;
		wr_en = 1'h1;
		@(negedge clock);
		wr_en = 1'h0;
		wdata = ~wdata;
	endtask
	task automatic rd(input spcr_addr_type a);
		@(negedge clock);
		addr = a;
		rd_en = 1'h1;
		@(negedge clock);
		rd_en = 1'h0;
	endtask
endmodule
`default_nettype wire

// ### sim/spcr_regs_tb_top.sv
// Purpose: Self-checking bench for the serial port configuration registers
// Assumes: Inputs change on the falling edge; read data checked one edge after the strobe
// Notes: Read phase held high except for one idle check, so both pin enables stay visible
`timescale 1ns/1ps
`default_nettype none
module spcr_regs_tb_top;
	import spcr_pkg::*;
	logic clock = 0, arst_n = 0, i2c_mode = 0, read_phase = 1, ext_buffered = 0;
	logic wr_en, rd_en, rvalid, unidir_mode_select, lsb_first, addr_increment, soft_reset, sdio_read_oe, serial_out_pin_oe;
	spcr_addr_type addr;
	spcr_byte_type wdata, rdata, ext_active_data = 8'h3c, ext_buffer_data = 8'hc3;
	int fail_count = 0, checks = 0, cycles = 0;
	always #2.5 clock = ~clock;
	spcr_host spcr_host_i(.clock, .wr_en, .rd_en, .addr, .wdata);
	spcr_regs spcr_regs_i(.clock, .arst_n, .i2c_mode, .wr_en, .rd_en, .addr, .wdata, .read_phase, .ext_buffered,
		.ext_active_data, .ext_buffer_data, .rdata, .rvalid, .unidir_mode_select, .lsb_first, .addr_increment,
		.soft_reset, .sdio_read_oe, .serial_out_pin_oe);
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch at %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic rdc(input spcr_addr_type a, input spcr_byte_type e);
		spcr_host_i.rd(a);
		chk({rvalid, rdata[7:1]}, {1'h1, e[7:1]});
		chk(rdata, e);
	endtask
	task wrap_up;
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	// Generous ceiling: the whole sequence needs well under a hundred cycles
	always @(posedge clock) begin
		cycles++;
		if (cycles > 500) begin
			fail_count++;
			wrap_up;
		end
	end
	initial begin
		repeat (20) @(negedge clock);
		arst_n = 1;
		rdc(12'h000, 8'h00);
		chk({6'h0, lsb_first, addr_increment}, 8'h00);
		chk({6'h0, sdio_read_oe, serial_out_pin_oe}, 8'h02);
		spcr_host_i.wr(12'h000, 8'h80);
		chk({5'h0, unidir_mode_select, sdio_read_oe, serial_out_pin_oe}, 8'h05);
		read_phase = 0;
		#1 chk({6'h0, sdio_read_oe, serial_out_pin_oe}, 8'h00);
		@(negedge clock) read_phase = 1;
		rdc(12'h000, 8'h81);
		spcr_host_i.wr(12'h000, 8'hc0);
		chk({5'h0, unidir_mode_select, lsb_first, addr_increment}, 8'h07);
		i2c_mode = 1;
		#1 chk({5'h0, unidir_mode_select, lsb_first, serial_out_pin_oe}, 8'h00);
		chk({6'h0, addr_increment, sdio_read_oe}, 8'h01);
		@(negedge clock) i2c_mode = 0;
		rdc(12'h010, 8'h3c);
		spcr_host_i.wr(12'h004, 8'h01);
		rdc(12'h004, 8'h01);
		ext_buffered = 1;
		rdc(12'h010, 8'hc3);
		ext_buffered = 0;
		rdc(12'h010, 8'h3c);
		spcr_host_i.wr(12'h000, 8'he0);
		chk({7'h0, soft_reset}, 8'h01);
		@(negedge clock) chk({5'h0, soft_reset, unidir_mode_select, addr_increment}, 8'h00);
		rdc(12'h000, 8'h00);
		rdc(12'h004, 8'h00);
		ext_buffered = 1;
		rdc(12'h010, 8'h3c);
		wrap_up;
	end
endmodule
`default_nettype wire
